//--- rtl/usbpf_pkg.sv
// Constants, register map and state types of the parallel FIFO port
package usbpf_pkg;
    localparam int CLK_MHZ = 50;
    localparam int FIFO_MHZ = 12;
    localparam int TX_DEPTH = 384;
    localparam int RX_DEPTH = 128;
    localparam int RST_OUT_MS = 5;
    localparam int MS_PER_S = 1000;
    localparam int TICKS_PER_MS = FIFO_MHZ * MS_PER_S;
    localparam int RST_OUT_CYCLES = CLK_MHZ * MS_PER_S * RST_OUT_MS;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] BAUD_OFS = 8'h08;
    localparam int CTRL_TMO_LSB = 0;
    localparam int CTRL_WAKE_BIT = 8;
    localparam int CTRL_PULL_BIT = 9;
    localparam int CTRL_ISO_BIT = 10;
    localparam logic [7:0] TMO_RESET = 8'h10;
    localparam logic [7:0] TMO_MIN = 8'h01;
    localparam int STAT_TXCNT_LSB = 0;
    localparam int STAT_RXCNT_LSB = 16;
    localparam int STAT_SUSP_BIT = 24;
    localparam int STAT_RESUME_BIT = 25;
    localparam int STAT_FLUSH_BIT = 26;
    typedef enum logic [1:0] {
        USBPF_IDLE = 2'b00,
        USBPF_LOW = 2'b01,
        USBPF_HOLD = 2'b10
    } usbpf_strobe_t;
endpackage : usbpf_pkg

//--- rtl/usbpf_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module usbpf_skid #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [W-1:0] spare_q;
    logic spare_valid_q;

    assign in_ready = !spare_valid_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_data <= '0;
            out_valid <= 1'b0;
            spare_q <= '0;
            spare_valid_q <= 1'b0;
        end else if (clr) begin
            out_valid <= 1'b0;
            spare_valid_q <= 1'b0;
        end else if (out_ready || !out_valid) begin
            if (spare_valid_q) begin
                out_data <= spare_q;
                out_valid <= 1'b1;
                spare_valid_q <= 1'b0;
            end else begin
                out_data <= in_data;
                out_valid <= in_valid;
            end
        end else if (in_valid && !spare_valid_q) begin
            spare_q <= in_data;
            spare_valid_q <= 1'b1;
        end
    end
endmodule : usbpf_skid

//--- rtl/usbpf_top.sv
// Byte-wide parallel FIFO port with USB-side byte streams and control registers
//
// Behaviour
// - tx_space_n goes high after each write, held while the byte is stored.
// - tx_space_n stays high while the 384-byte transmit buffer is full.
// - rx_avail_n is low whenever the receive buffer holds a byte and no read is in progress.
// - rx_avail_n goes high after each read, returns low only if data remains.
// - The receive buffer holds 128 bytes.
// - Baud rate settings are ignored; data always moves at full rate.
// - bus_power_on_n is high while suspended or not configured.
// - With pull-down option set, FIFO lines pulled weakly low while power off.
// - Wake strobe during suspend with remote wakeup enabled requests resume.
// - Wake strobe in normal operation flushes buffered data on next IN request.
// - Flush timeout programmable 1 to 255 ms; residual data flushed on expiry.
// - Isochronous transfers used when the option bit is set.
// - An active-low external reset input resets the port besides power-on reset.
// - Each low pulse of the read strobe removes one byte.
// - Each low pulse of the write strobe stores one byte.
// - The FIFO controller steps on a 12 MHz enable derived from the clock.
// - reset_out_n stays low about 5 ms after external reset rises.
`timescale 1ns/10ps
module usbpf_top #(
    parameter int TX_DEPTH = usbpf_pkg::TX_DEPTH,
    parameter int RX_DEPTH = usbpf_pkg::RX_DEPTH,
    parameter int TICKS_PER_MS = usbpf_pkg::TICKS_PER_MS,
    parameter int RST_OUT_CYCLES = usbpf_pkg::RST_OUT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ext_reset_n,
    output logic reset_out_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic tx_space_n,
    output logic rx_avail_n,
    input wire logic send_now_wake_n,
    output logic bus_power_on_n,
    output logic fifo_pull_down,
    input wire logic [7:0] usb_rx_data,
    input wire logic usb_rx_valid,
    output logic usb_rx_ready,
    output logic [7:0] usb_tx_data,
    output logic usb_tx_valid,
    input wire logic usb_tx_ready,
    input wire logic usb_in_req,
    output logic usb_flush,
    input wire logic usb_suspend,
    input wire logic usb_configured,
    output logic usb_resume_req,
    output logic usb_iso,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    localparam int TXW = $clog2(TX_DEPTH + 1);
    localparam int RXW = $clog2(RX_DEPTH + 1);
    localparam int TXP = $clog2(TX_DEPTH);
    localparam int RXP = $clog2(RX_DEPTH);
    localparam int MSW = $clog2(TICKS_PER_MS + 1);
    localparam int ROW = $clog2(RST_OUT_CYCLES + 1);

    if (TX_DEPTH < 2 || RX_DEPTH < 2 || TICKS_PER_MS < 1 || RST_OUT_CYCLES < 1) begin : g_bad
        $error("usbpf_top: depths or counts out of range");
    end

    // Two-flop synchronisers for the pins
    logic [11:0] pin_s1_q;
    logic [11:0] pin_s2_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= 12'hfff;
            pin_s2_q <= 12'hfff;
        end else begin
            pin_s1_q <= {ext_reset_n, send_now_wake_n, rd_n, wr_n, data_in};
            pin_s2_q <= pin_s1_q;
        end
    end
    logic ext_rst_s;
    logic wake_s;
    logic rd_s;
    logic wr_s;
    logic [7:0] din_s;
    assign {ext_rst_s, wake_s, rd_s, wr_s, din_s} = pin_s2_q;

    // External reset clears the port state synchronously
    logic soft_rst;
    assign soft_rst = !ext_rst_s;

    // Reset output held low after external reset is released
    logic [ROW-1:0] ro_cnt_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ro_cnt_q <= '0;
            reset_out_n <= 1'b0;
        end else if (soft_rst) begin
            ro_cnt_q <= '0;
            reset_out_n <= 1'b0;
        end else if (ro_cnt_q != ROW'(RST_OUT_CYCLES)) begin
            ro_cnt_q <= ro_cnt_q + 1'b1;
        end else begin
            reset_out_n <= 1'b1;
        end
    end

    // 12 MHz step enable from the 50 MHz clock
    logic [6:0] div_acc_q;
    logic tick_q;
    logic [6:0] div_sum;
    assign div_sum = div_acc_q + 7'(usbpf_pkg::FIFO_MHZ);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_acc_q <= '0;
            tick_q <= 1'b0;
        end else if (div_sum >= 7'(usbpf_pkg::CLK_MHZ)) begin
            div_acc_q <= div_sum - 7'(usbpf_pkg::CLK_MHZ);
            tick_q <= 1'b1;
        end else begin
            div_acc_q <= div_sum;
            tick_q <= 1'b0;
        end
    end

    // Strobe levels seen at the previous step
    logic wr_prev_q;
    logic rd_prev_q;
    logic wake_prev_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
            wake_prev_q <= 1'b1;
        end else if (tick_q) begin
            wr_prev_q <= wr_s;
            rd_prev_q <= rd_s;
            wake_prev_q <= wake_s;
        end
    end
    logic wake_fall;
    assign wake_fall = tick_q && wake_prev_q && !wake_s;

    // Control register
    logic [7:0] tmo_ms_q;
    logic wake_en_q;
    logic pull_en_q;
    logic iso_en_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tmo_ms_q <= usbpf_pkg::TMO_RESET;
            wake_en_q <= 1'b0;
            pull_en_q <= 1'b0;
            iso_en_q <= 1'b0;
        end else if (reg_wr && reg_addr == usbpf_pkg::CTRL_OFS) begin
            tmo_ms_q <= reg_wdata[usbpf_pkg::CTRL_TMO_LSB +: 8];
            wake_en_q <= reg_wdata[usbpf_pkg::CTRL_WAKE_BIT];
            pull_en_q <= reg_wdata[usbpf_pkg::CTRL_PULL_BIT];
            iso_en_q <= reg_wdata[usbpf_pkg::CTRL_ISO_BIT];
        end
    end
    // Writes to the baud register are accepted and discarded

    // Transmit buffer: pin side writes, USB side drains at full rate
    logic [7:0] tx_mem [TX_DEPTH];
    logic [TXP-1:0] tx_wp_q;
    logic [TXP-1:0] tx_rp_q;
    logic [TXW-1:0] tx_cnt_q;
    usbpf_pkg::usbpf_strobe_t tx_st_q;
    logic tx_push;
    logic tx_pop;
    logic skid_in_ready;
    logic tx_full;
    assign tx_full = tx_cnt_q == TXW'(TX_DEPTH);
    // Store on the rising end of the write strobe
    assign tx_push = tick_q && tx_st_q == usbpf_pkg::USBPF_LOW && wr_s && !tx_full;
    assign tx_pop = skid_in_ready && tx_cnt_q != '0 && !soft_rst;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_st_q <= usbpf_pkg::USBPF_IDLE;
        end else if (soft_rst) begin
            tx_st_q <= usbpf_pkg::USBPF_IDLE;
        end else if (tick_q) begin
            case (tx_st_q)
                usbpf_pkg::USBPF_IDLE: begin
                    if (wr_prev_q && !wr_s && !tx_full) begin
                        tx_st_q <= usbpf_pkg::USBPF_LOW;
                    end
                end
                usbpf_pkg::USBPF_LOW: begin
                    if (wr_s) begin
                        tx_st_q <= usbpf_pkg::USBPF_HOLD;
                    end
                end
                usbpf_pkg::USBPF_HOLD: begin
                    tx_st_q <= usbpf_pkg::USBPF_IDLE;
                end
                default: begin
                    tx_st_q <= usbpf_pkg::USBPF_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (tx_push) begin
            tx_mem[tx_wp_q] <= din_s;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            tx_cnt_q <= '0;
        end else if (soft_rst) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            tx_cnt_q <= '0;
        end else begin
            if (tx_push) begin
                tx_wp_q <= (tx_wp_q == TXP'(TX_DEPTH - 1)) ? '0 : tx_wp_q + 1'b1;
            end
            if (tx_pop) begin
                tx_rp_q <= (tx_rp_q == TXP'(TX_DEPTH - 1)) ? '0 : tx_rp_q + 1'b1;
            end
            if (tx_push && !tx_pop) begin
                tx_cnt_q <= tx_cnt_q + 1'b1;
            end else if (tx_pop && !tx_push) begin
                tx_cnt_q <= tx_cnt_q - 1'b1;
            end
        end
    end

    // Space flag: high while a write is in progress or the buffer is full
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_space_n <= 1'b1;
        end else begin
            tx_space_n <= soft_rst || tx_st_q != usbpf_pkg::USBPF_IDLE
                || tx_full;
        end
    end

    usbpf_skid #(
        .W(8)
    ) u_tx_skid (
        .core_clk(core_clk),
        .rst(rst),
        .clr(soft_rst),
        .in_data(tx_mem[tx_rp_q]),
        .in_valid(tx_pop),
        .in_ready(skid_in_ready),
        .out_data(usb_tx_data),
        .out_valid(usb_tx_valid),
        .out_ready(usb_tx_ready)
    );

    // Receive buffer: USB side fills, pin side reads
    logic [7:0] rx_mem [RX_DEPTH];
    logic [RXP-1:0] rx_wp_q;
    logic [RXP-1:0] rx_rp_q;
    logic [RXW-1:0] rx_cnt_q;
    logic [RXW-1:0] rx_cnt_d;
    usbpf_pkg::usbpf_strobe_t rx_st_q;
    logic rx_push;
    logic rx_pop;
    assign rx_push = usb_rx_valid && usb_rx_ready && !soft_rst;
    assign rx_pop = tick_q && rx_st_q == usbpf_pkg::USBPF_LOW && rd_s && !soft_rst;

    always_comb begin
        rx_cnt_d = rx_cnt_q;
        if (soft_rst) begin
            rx_cnt_d = '0;
        end else if (rx_push && !rx_pop) begin
            rx_cnt_d = rx_cnt_q + 1'b1;
        end else if (rx_pop && !rx_push) begin
            rx_cnt_d = rx_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rx_push) begin
            rx_mem[rx_wp_q] <= usb_rx_data;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            rx_cnt_q <= '0;
            usb_rx_ready <= 1'b0;
        end else begin
            rx_cnt_q <= rx_cnt_d;
            usb_rx_ready <= rx_cnt_d != RXW'(RX_DEPTH);
            if (soft_rst) begin
                rx_wp_q <= '0;
                rx_rp_q <= '0;
            end else begin
                if (rx_push) begin
                    rx_wp_q <= (rx_wp_q == RXP'(RX_DEPTH - 1)) ? '0 : rx_wp_q + 1'b1;
                end
                if (rx_pop) begin
                    rx_rp_q <= (rx_rp_q == RXP'(RX_DEPTH - 1)) ? '0 : rx_rp_q + 1'b1;
                end
            end
        end
    end

    // Read strobe sequencing and data bus drive
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_st_q <= usbpf_pkg::USBPF_IDLE;
            data_out <= '0;
            data_oe <= 1'b0;
        end else if (soft_rst) begin
            rx_st_q <= usbpf_pkg::USBPF_IDLE;
            data_oe <= 1'b0;
        end else if (tick_q) begin
            case (rx_st_q)
                usbpf_pkg::USBPF_IDLE: begin
                    if (rd_prev_q && !rd_s && rx_cnt_q != '0) begin
                        rx_st_q <= usbpf_pkg::USBPF_LOW;
                        data_out <= rx_mem[rx_rp_q];
                        data_oe <= 1'b1;
                    end
                end
                usbpf_pkg::USBPF_LOW: begin
                    if (rd_s) begin
                        rx_st_q <= usbpf_pkg::USBPF_HOLD;
                        data_oe <= 1'b0;
                    end
                end
                usbpf_pkg::USBPF_HOLD: begin
                    rx_st_q <= usbpf_pkg::USBPF_IDLE;
                end
                default: begin
                    rx_st_q <= usbpf_pkg::USBPF_IDLE;
                end
            endcase
        end
    end

    // Availability flag: low only when idle with data buffered
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_avail_n <= 1'b1;
        end else begin
            rx_avail_n <= !(rx_st_q == usbpf_pkg::USBPF_IDLE
                && rx_cnt_q != '0 && !soft_rst);
        end
    end

    // Millisecond timer for the flush timeout
    logic [MSW-1:0] ms_div_q;
    logic [7:0] ms_cnt_q;
    logic [7:0] tmo_eff;
    logic tmo_hit;
    assign tmo_eff = (tmo_ms_q == '0) ? usbpf_pkg::TMO_MIN : tmo_ms_q;
    assign tmo_hit = tick_q && ms_div_q == MSW'(TICKS_PER_MS - 1) && ms_cnt_q + 8'h01 >= tmo_eff;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ms_div_q <= '0;
            ms_cnt_q <= '0;
        end else if (soft_rst || tx_push || tx_cnt_q == '0 || tmo_hit) begin
            ms_div_q <= '0;
            ms_cnt_q <= '0;
        end else if (tick_q) begin
            if (ms_div_q == MSW'(TICKS_PER_MS - 1)) begin
                ms_div_q <= '0;
                ms_cnt_q <= ms_cnt_q + 1'b1;
            end else begin
                ms_div_q <= ms_div_q + 1'b1;
            end
        end
    end

    // Flush request: set by timeout or send-now strobe, served by next IN request
    logic flush_set;
    assign flush_set = tmo_hit || (wake_fall && !usb_suspend);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            usb_flush <= 1'b0;
        end else if (soft_rst) begin
            usb_flush <= 1'b0;
        end else if (flush_set) begin
            usb_flush <= 1'b1;
        end else if (usb_in_req) begin
            usb_flush <= 1'b0;
        end
    end

    // Suspend handling: resume request, power indication, pull-down, transfer type
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            usb_resume_req <= 1'b0;
            bus_power_on_n <= 1'b1;
            fifo_pull_down <= 1'b0;
            usb_iso <= 1'b0;
        end else begin
            if (wake_fall && usb_suspend && wake_en_q) begin
                usb_resume_req <= 1'b1;
            end else if (!usb_suspend || soft_rst) begin
                usb_resume_req <= 1'b0;
            end
            bus_power_on_n <= usb_suspend || !usb_configured;
            fifo_pull_down <= pull_en_q && (usb_suspend || !usb_configured);
            usb_iso <= iso_en_q;
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            case (reg_addr)
                usbpf_pkg::CTRL_OFS: begin
                    reg_rdata[usbpf_pkg::CTRL_TMO_LSB +: 8] <= tmo_ms_q;
                    reg_rdata[usbpf_pkg::CTRL_WAKE_BIT] <= wake_en_q;
                    reg_rdata[usbpf_pkg::CTRL_PULL_BIT] <= pull_en_q;
                    reg_rdata[usbpf_pkg::CTRL_ISO_BIT] <= iso_en_q;
                end
                usbpf_pkg::STAT_OFS: begin
                    reg_rdata[usbpf_pkg::STAT_TXCNT_LSB +: TXW] <= tx_cnt_q;
                    reg_rdata[usbpf_pkg::STAT_RXCNT_LSB +: RXW] <= rx_cnt_q;
                    reg_rdata[usbpf_pkg::STAT_SUSP_BIT] <= usb_suspend;
                    reg_rdata[usbpf_pkg::STAT_RESUME_BIT] <= usb_resume_req;
                    reg_rdata[usbpf_pkg::STAT_FLUSH_BIT] <= usb_flush;
                end
                default: begin
                    reg_rdata <= '0;
                end
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule : usbpf_top

//--- dv/usbpf_top_chk.sv
// Concurrent checks on the ports of the parallel FIFO port
`timescale 1ns/10ps
module usbpf_top_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ext_reset_n,
    input wire logic reset_out_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic data_oe,
    input wire logic tx_space_n,
    input wire logic rx_avail_n,
    input wire logic bus_power_on_n,
    input wire logic fifo_pull_down,
    input wire logic usb_flush,
    input wire logic usb_suspend,
    input wire logic usb_resume_req,
    input wire logic usb_iso,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_space_after_wr: assert property ($fell(wr_n) && !tx_space_n |-> ##[1:12] tx_space_n)
        else $error("no space flag after write");
    a_avail_after_rd: assert property ($fell(rd_n) && !rx_avail_n |-> ##[1:12] rx_avail_n)
        else $error("no avail flag after read");
    a_oe_in_read: assert property ($rose(data_oe) |-> !rd_n)
        else $error("data bus driven outside read");
    a_power_on_susp: assert property ($rose(usb_suspend) |-> ##[1:3] bus_power_on_n)
        else $error("power flag low during suspend");
    a_pull_when_off: assert property ($rose(fifo_pull_down) |-> ##[0:2] bus_power_on_n)
        else $error("pull-down while power on");
    a_resume_in_susp: assert property ($rose(usb_resume_req) |-> $past(usb_suspend))
        else $error("resume request outside suspend");
    a_baud_reads_zero: assert property (reg_rd && reg_addr == usbpf_pkg::BAUD_OFS |=>
        reg_rdata == 32'h0) else $error("baud register not ignored");
    a_iso_follows: assert property (reg_wr && reg_addr == usbpf_pkg::CTRL_OFS &&
        reg_wdata[usbpf_pkg::CTRL_ISO_BIT] |-> ##[1:2] usb_iso) else $error("iso option lost");
    a_ext_rst_flags: assert property ($fell(ext_reset_n) |-> ##[1:6] tx_space_n && rx_avail_n)
        else $error("flags low in external reset");
    a_rst_out_low: assert property ($fell(ext_reset_n) |-> ##[1:6] !reset_out_n)
        else $error("reset output not lowered");
    cover property ($fell(wr_n) && !tx_space_n);
    cover property ($rose(usb_resume_req));
    cover property ($rose(usb_flush));
endmodule : usbpf_top_chk

bind usbpf_top usbpf_top_chk usbpf_top_chk_inst (.core_clk, .rst, .ext_reset_n, .reset_out_n,
    .wr_n, .rd_n, .data_oe, .tx_space_n, .rx_avail_n, .bus_power_on_n, .fifo_pull_down,
    .usb_flush, .usb_suspend, .usb_resume_req, .usb_iso, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata);

//--- dv/usbpf_mcu.sv
// Model of the outside logic that strobes the FIFO pins
`timescale 1ns/10ps
module usbpf_mcu (
    input wire logic core_clk,
    input wire logic tx_space_n,
    input wire logic rx_avail_n,
    input wire logic [7:0] data_out,
    output logic wr_n,
    output logic rd_n,
    output logic [7:0] data_in
);
    initial begin
        wr_n = 1'b1;
        rd_n = 1'b1;
        data_in = 8'h5a;
    end
    // One low pulse stores one byte
    task automatic put(input logic [7:0] b, input int lim, output bit ok);
        int i;
        @(posedge core_clk);
        for (i = 0; i < lim && tx_space_n !== 1'b0; i++) @(posedge core_clk);
        ok = (tx_space_n === 1'b0);
        if (ok) begin
            wr_n <= 1'b0;
            data_in <= b;
            repeat (12) @(posedge core_clk);
            wr_n <= 1'b1;
            repeat (6) @(posedge core_clk);
            data_in <= ~b;
            repeat (6) @(posedge core_clk);
        end
    endtask : put
    // One low pulse removes one byte
    task automatic get(input int lim, output logic [7:0] b, output bit ok);
        int i;
        @(posedge core_clk);
        for (i = 0; i < lim && rx_avail_n !== 1'b0; i++) @(posedge core_clk);
        ok = (rx_avail_n === 1'b0);
        b = 8'h00;
        if (ok) begin
            rd_n <= 1'b0;
            repeat (12) @(posedge core_clk);
            b = data_out;
            rd_n <= 1'b1;
            repeat (12) @(posedge core_clk);
        end
    endtask : get
endmodule : usbpf_mcu

//--- dv/usbpf_top_test.sv
// Self-checking bench for the parallel FIFO port
`timescale 1ns/10ps
module usbpf_top_test;
    localparam int TXD = 4;
    localparam int RXD = 4;
    localparam int RSTC = 20;
    logic core_clk, rst, ext_reset_n, reset_out_n, wr_n, rd_n, data_oe, tx_space_n;
    logic rx_avail_n, send_now_wake_n, bus_power_on_n, fifo_pull_down, usb_rx_valid;
    logic usb_rx_ready, usb_tx_valid, usb_tx_ready, usb_in_req, usb_flush, usb_suspend;
    logic usb_configured, usb_resume_req, usb_iso, reg_wr, reg_rd;
    logic [7:0] data_in, data_out, usb_rx_data, usb_tx_data, reg_addr, b;
    logic [31:0] reg_wdata, reg_rdata, d;
    int fail_count = 0, checks_done = 0, cycles = 0, n, m, k;
    bit ok;
    usbpf_top #(.TX_DEPTH(TXD), .RX_DEPTH(RXD), .TICKS_PER_MS(12), .RST_OUT_CYCLES(RSTC))
    usbpf_top_inst (.core_clk, .rst, .ext_reset_n, .reset_out_n, .wr_n, .rd_n, .data_in,
        .data_out, .data_oe, .tx_space_n, .rx_avail_n, .send_now_wake_n, .bus_power_on_n,
        .fifo_pull_down, .usb_rx_data, .usb_rx_valid, .usb_rx_ready, .usb_tx_data,
        .usb_tx_valid, .usb_tx_ready, .usb_in_req, .usb_flush, .usb_suspend, .usb_configured,
        .usb_resume_req, .usb_iso, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    usbpf_mcu usbpf_mcu_inst (.core_clk, .tx_space_n, .rx_avail_n, .data_out, .wr_n, .rd_n,
        .data_in);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : reg_read
    task automatic wake_pulse();
        @(posedge core_clk);
        send_now_wake_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        send_now_wake_n <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask : wake_pulse
    initial begin
        rst = 1'b1;
        ext_reset_n = 1'b1;
        send_now_wake_n = 1'b1;
        {usb_rx_valid, usb_tx_ready, usb_in_req, usb_suspend, usb_configured} = 5'h00;
        {usb_rx_data, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        repeat (6) @(posedge core_clk);
        cmp({tx_space_n, rx_avail_n, bus_power_on_n, reset_out_n, usb_tx_valid}, 32'h1c);
        rst <= 1'b0;
        reg_read(usbpf_pkg::CTRL_OFS, d);
        cmp(d, {24'h0, usbpf_pkg::TMO_RESET});
        reg_read(usbpf_pkg::STAT_OFS, d);
        cmp(d, 32'h0);
        reg_write(usbpf_pkg::BAUD_OFS, 32'hffffffff);
        reg_read(usbpf_pkg::BAUD_OFS, d);
        cmp(d, 32'h0);
        reg_read(8'h0c, d);
        cmp(d, 32'h0);
        reg_write(usbpf_pkg::CTRL_OFS, 32'h702);
        reg_read(usbpf_pkg::CTRL_OFS, d);
        cmp(d, 32'h702);
        cmp({usb_iso, bus_power_on_n, fifo_pull_down}, 32'h7);
        usb_configured <= 1'b1;
        repeat (4) @(posedge core_clk);
        cmp({bus_power_on_n, fifo_pull_down}, 32'h0);
        for (k = 0; k < RSTC + 40 && reset_out_n !== 1'b1; k++) @(posedge core_clk);
        cmp(reset_out_n, 32'h1);
        n = 0;
        for (k = 0; k < TXD + 4; k++) begin
            usbpf_mcu_inst.put(8'ha0 + k[7:0], 100, ok);
            if (ok) n++;
            else break;
        end
        cmp(n, TXD + 2);
        cmp(tx_space_n, 32'h1);
        for (k = 0; k < 400 && usb_flush !== 1'b1; k++) @(posedge core_clk);
        cmp(usb_flush, 32'h1);
        usb_in_req <= 1'b1;
        @(posedge core_clk);
        usb_in_req <= 1'b0;
        usb_tx_ready <= 1'b1;
        m = 0;
        repeat (60) begin
            @(negedge core_clk);
            if (usb_tx_valid === 1'b1) begin
                cmp(usb_tx_data, 8'ha0 + m);
                m++;
            end
        end
        cmp(m, n);
        cmp({tx_space_n, usb_flush}, 32'h0);
        usb_tx_ready <= 1'b0;
        usbpf_mcu_inst.put(8'h3c, 100, ok);
        wake_pulse();
        cmp(usb_flush, 32'h1);
        usb_tx_ready <= 1'b1;
        usb_rx_valid <= 1'b1;
        usb_rx_data <= 8'hc0;
        k = 0;
        repeat (40) begin
            @(negedge core_clk);
            if (usb_rx_ready === 1'b1) k++;
            @(posedge core_clk);
            usb_rx_data <= 8'hc0 + k[7:0];
        end
        usb_rx_valid <= 1'b0;
        cmp(k, RXD);
        cmp(rx_avail_n, 32'h0);
        for (m = 0; m < k; m++) begin
            usbpf_mcu_inst.get(40, b, ok);
            cmp(b, 8'hc0 + m);
        end
        repeat (12) @(posedge core_clk);
        cmp(rx_avail_n, 32'h1);
        usb_suspend <= 1'b1;
        repeat (4) @(posedge core_clk);
        cmp({bus_power_on_n, fifo_pull_down}, 32'h3);
        wake_pulse();
        cmp(usb_resume_req, 32'h1);
        usb_suspend <= 1'b0;
        repeat (4) @(posedge core_clk);
        cmp({usb_resume_req, bus_power_on_n}, 32'h0);
        usb_rx_valid <= 1'b1;
        repeat (10) @(posedge core_clk);
        usb_rx_valid <= 1'b0;
        cmp(rx_avail_n, 32'h0);
        ext_reset_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        cmp({rx_avail_n, reset_out_n}, 32'h2);
        ext_reset_n <= 1'b1;
        reg_read(usbpf_pkg::CTRL_OFS, d);
        cmp(d, 32'h702);
        for (k = 0; k < RSTC + 40 && reset_out_n !== 1'b1; k++) @(posedge core_clk);
        cmp({reset_out_n, rx_avail_n}, 32'h3);
        test_done();
    end
endmodule : usbpf_top_test
